// file: hw/rsc_pkg.sv
// Shared constants, encodings and carriers of the run/stop and error control block
package rsc_pkg;

  // Sizes
  localparam int CODE_W = 16;
  localparam int STACK_DEPTH = 5;
  localparam int NUM_X = 16;
  localparam int NUM_Y = 16;
  localparam int NUM_SYS = 4;
  localparam int SYS_SERIOUS_NUM = 2;
  localparam int NUM_CLR = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PATTERN = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SYS_CODE = 8'h0c;
  localparam logic [7:0] OFS_STACK0 = 8'h10;
  localparam logic [7:0] OFS_STACK_LAST = 8'h20;

  // Status bit positions
  localparam int ST_BIT_RUN = 0;
  localparam int ST_BIT_SYS_FLAG = 1;
  localparam int ST_BIT_EXEC_FLAG = 2;
  localparam int ST_BIT_LAMP = 3;
  localparam int ST_BIT_UPLOAD = 4;

  // Reset values and system error code base
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [15:0] PATTERN_RST = 16'h0000;
  localparam logic [15:0] SYS_CODE_BASE = 16'h0001;

  // Stop-state output policy field encoding
  typedef enum logic [1:0] {
    OUT_OFF = 2'h0,
    OUT_FREEZE = 2'h1,
    OUT_PATTERN = 2'h2
  } rsc_policy_e;

  // Mode switch pin encoding
  typedef enum logic [1:0] {
    SW_OFF = 2'h0,
    SW_PROG_ONLY = 2'h1,
    SW_ON = 2'h2
  } rsc_switch_e;

  typedef enum {
    ST_BOOT,
    ST_STOP,
    ST_RUN
  } rsc_state_e;

  typedef struct packed {
    logic [3:0] start_idx;
    logic startup_en;
    logic ctrl_en;
    logic [1:0] policy;
  } rsc_ctrl_s;

  typedef struct packed {
    logic user_prog;
    logic comm;
    logic internal;
    logic io_update;
  } rsc_tasks_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
  } rsc_bus_s;

endpackage

// file: hw/rsc_err_stack.sv
// Five-deep execution error code stack
`timescale 1ns/1ps
`default_nettype none
module rsc_err_stack import rsc_pkg::*; #(
  parameter int DEPTH = STACK_DEPTH,
  parameter int WIDTH = CODE_W
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // New error code
  input wire logic push_in,
  input wire logic [WIDTH-1:0] code_in,
  // Stored codes, slot 0 is the newest
  output logic [DEPTH-1:0][WIDTH-1:0] stack_out
);

  initial begin
    if (DEPTH < 2) $error("stack needs at least two slots");
  end

  // A repeat of the newest code leaves the history alone
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      stack_out <= '0;
    end else if (push_in && code_in != stack_out[0]) begin
      stack_out <= {stack_out[DEPTH-2:0], code_in};
    end
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  stack_push_a: assert property (push_in && code_in != stack_out[0] |=>
    stack_out[0] == $past(code_in) && stack_out[1] == $past(stack_out[0]))
    else $error("stack did not push a new code");
  stack_hold_a: assert property (push_in && code_in == stack_out[0] |=> $stable(stack_out))
    else $error("stack moved on a repeated code");
  stack_push_c: cover property (push_in && code_in != stack_out[0] && stack_out[0] != '0);

endmodule // rsc_err_stack
`default_nettype wire

// file: hw/rsc_run_stop.sv
// Run/stop state control, stop-state outputs and error reporting
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rsc_run_stop import rsc_pkg::*; #(
  parameter int NX = NUM_X,
  parameter int NY = NUM_Y,
  parameter int NSYS = NUM_SYS,
  parameter int NSERIOUS = SYS_SERIOUS_NUM
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Register port
  input wire rsc_bus_s bus_in,
  output logic [31:0] rd_data_out,
  // Pins
  input wire logic [1:0] switch_pin_in,
  input wire logic [NX-1:0] x_pin_in,
  // Scan engine
  input wire logic scan_end_in,
  input wire logic [NY-1:0] y_image_in,
  input wire logic stop_cmd_in,
  input wire logic [NSYS-1:0] sys_err_req_in,
  input wire logic exec_err_in,
  input wire logic [CODE_W-1:0] exec_err_code_in,
  input wire logic exec_err_serious_in,
  input wire logic exec_ok_in,
  // Programming computer
  input wire logic [NUM_CLR-1:0] clr_req_in,
  input wire logic dl_done_in,
  input wire logic dl_upload_en_in,
  input wire logic upload_req_in,
  // Results
  output rsc_tasks_s tasks_out,
  output logic run_out,
  output logic [NY-1:0] y_out,
  output logic err_lamp_out,
  output logic [NUM_CLR-1:0] clr_go_out,
  output logic clr_refused_out,
  output logic upload_grant_out,
  output logic upload_refused_out,
  output logic prog_swap_out
);

  initial begin
    if (NX != 16) $error("start index field serves exactly 16 inputs");
    if (NY < 1 || NY > 32) $error("output count must be 1 to 32");
    if (NSERIOUS > NSYS || NSYS > 16) $error("bad system error counts");
  end

  function automatic logic [CODE_W-1:0] sys_code(input int idx);
    sys_code = SYS_CODE_BASE + CODE_W'(idx);
  endfunction

  rsc_state_e state;
  rsc_state_e next_state;
  rsc_ctrl_s ctrl;
  logic [NY-1:0] pattern;
  logic [1:0] sw_s1;
  logic [1:0] sw_s2;
  logic [NX-1:0] x_s1;
  logic [NX-1:0] x_s2;
  logic sw_was_on;
  logic x_was;
  logic stop_pend;
  logic fault_pend;
  logic sys_flag;
  logic [CODE_W-1:0] sys_code_reg;
  logic exec_flag;
  logic upload_en;
  logic [STACK_DEPTH-1:0][CODE_W-1:0] exec_stack;
  logic sw_on;
  logic sel_x;
  logic sys_serious;
  logic fault_now;
  logic [CODE_W-1:0] worst_code;
  logic [NY-1:0] stop_val;

  // Only the second synchroniser stage is read below
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sw_s1 <= SW_OFF;
      sw_s2 <= SW_OFF;
      x_s1 <= '0;
      x_s2 <= '0;
    end else begin
      sw_s1 <= switch_pin_in;
      sw_s2 <= sw_s1;
      x_s1 <= x_pin_in;
      x_s2 <= x_s1;
    end
  end

  assign sw_on = (sw_s2 == SW_ON);
  assign sel_x = x_s2[ctrl.start_idx];

  always_comb begin
    sys_serious = 1'b0;
    worst_code = '0;
    // Lowest request index is the most severe
    for (int i = NSYS - 1; i >= 0; i--) begin
      if (sys_err_req_in[i]) begin
        worst_code = sys_code(i);
      end
    end
    for (int i = 0; i < NSERIOUS; i++) begin
      if (sys_err_req_in[i]) begin
        sys_serious = 1'b1;
      end
    end
  end

  assign fault_now = sys_serious || (exec_err_in && exec_err_serious_in);

  // Requests held until the scan boundary; a fresh one wins over the clear
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      stop_pend <= 1'b0;
      fault_pend <= 1'b0;
    end else begin
      stop_pend <= stop_cmd_in || (stop_pend && !scan_end_in);
      fault_pend <= fault_now || (fault_pend && !scan_end_in);
    end
  end

  always_comb begin
    next_state = state;
    if (scan_end_in) begin
      unique case (state)
        ST_BOOT: begin
          if (sw_on && (!ctrl.ctrl_en || sel_x)) begin
            next_state = ST_RUN;
          end else begin
            next_state = ST_STOP;
          end
        end
        ST_RUN: begin
          if (sw_s2 == SW_OFF || stop_pend || fault_pend) begin
            next_state = ST_STOP;
          end
        end
        ST_STOP: begin
          if (sw_on && (!sw_was_on || (ctrl.startup_en && sel_x && !x_was))) begin
            next_state = ST_RUN;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      state <= ST_BOOT;
      sw_was_on <= 1'b0;
      x_was <= 1'b0;
    end else begin
      state <= next_state;
      if (scan_end_in) begin
        sw_was_on <= sw_on;
        x_was <= sel_x;
      end
    end
  end

  // Outputs follow the state being entered, so the policy holds from the first stopped scan
  always_comb begin
    unique case (rsc_policy_e'(ctrl.policy))
      OUT_FREEZE: stop_val = y_out;
      OUT_PATTERN: stop_val = pattern;
      default: stop_val = '0;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      y_out <= '0;
      run_out <= 1'b0;
      tasks_out <= '0;
    end else begin
      y_out <= (next_state == ST_RUN) ? y_image_in : stop_val;
      run_out <= (next_state == ST_RUN);
      tasks_out.user_prog <= (next_state == ST_RUN) && !fault_now && !fault_pend;
      tasks_out.comm <= 1'b1;
      tasks_out.internal <= 1'b1;
      tasks_out.io_update <= 1'b1;
    end
  end

  // System error flag; a new error beats a software clear in the same cycle
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      sys_flag <= 1'b0;
      sys_code_reg <= '0;
    end else if (|sys_err_req_in) begin
      sys_flag <= 1'b1;
      sys_code_reg <= worst_code;
    end else if (bus_in.wr && bus_in.addr == OFS_STATUS && bus_in.wdata[ST_BIT_SYS_FLAG]) begin
      sys_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      exec_flag <= 1'b0;
    end else if (exec_err_in) begin
      exec_flag <= 1'b1;
    end else if (exec_ok_in) begin
      exec_flag <= 1'b0;
    end
  end

  // Lamp stays lit until reset
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      err_lamp_out <= 1'b0;
    end else if (fault_now) begin
      err_lamp_out <= 1'b1;
    end
  end

  rsc_err_stack #(
    .DEPTH(STACK_DEPTH),
    .WIDTH(CODE_W)
  ) u_stack (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .push_in(exec_err_in),
    .code_in(exec_err_code_in),
    .stack_out(exec_stack)
  );

  // Destructive operations only while stopped
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      clr_go_out <= '0;
      clr_refused_out <= 1'b0;
    end else begin
      clr_go_out <= (state == ST_STOP) ? clr_req_in : '0;
      clr_refused_out <= (state != ST_STOP) && (|clr_req_in);
    end
  end

  // Download complete swaps in the new program, also in RUN for online edits
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      prog_swap_out <= 1'b0;
    end else begin
      prog_swap_out <= dl_done_in;
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      upload_en <= 1'b1;
      upload_grant_out <= 1'b0;
      upload_refused_out <= 1'b0;
    end else begin
      if (dl_done_in) begin
        upload_en <= dl_upload_en_in;
      end
      upload_grant_out <= upload_req_in && upload_en;
      upload_refused_out <= upload_req_in && !upload_en;
    end
  end

  // Register writes
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      ctrl <= CTRL_RST;
      pattern <= NY'(PATTERN_RST);
    end else if (bus_in.wr) begin
      if (bus_in.addr == OFS_CTRL) begin
        ctrl <= bus_in.wdata[7:0];
      end
      if (bus_in.addr == OFS_PATTERN) begin
        pattern <= bus_in.wdata[NY-1:0];
      end
    end
  end

  // Register reads, data in the following cycle only
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= '0;
      if (bus_in.rd) begin
        if (bus_in.addr == OFS_CTRL) begin
          rd_data_out <= {24'h000000, ctrl};
        end else if (bus_in.addr == OFS_PATTERN) begin
          rd_data_out <= 32'(pattern);
        end else if (bus_in.addr == OFS_STATUS) begin
          rd_data_out <= {27'h0000000, upload_en, err_lamp_out, exec_flag, sys_flag, run_out};
        end else if (bus_in.addr == OFS_SYS_CODE) begin
          rd_data_out <= {16'h0000, sys_code_reg};
        end else if (bus_in.addr >= OFS_STACK0 && bus_in.addr <= OFS_STACK_LAST && bus_in.addr[1:0] == 2'h0) begin
          rd_data_out <= {16'h0000, exec_stack[3'((bus_in.addr - OFS_STACK0) >> 2)]};
        end
      end
    end
  end

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  boot_run_a: assert property (state == ST_BOOT && scan_end_in && sw_on && !ctrl.ctrl_en |=>
    state == ST_RUN && run_out && tasks_out.user_prog)
    else $error("reset with switch on did not run");
  boot_gate_a: assert property (state == ST_BOOT && scan_end_in && ctrl.ctrl_en && !sel_x |=>
    state == ST_STOP)
    else $error("input control did not hold stop");
  stop_switch_a: assert property (state == ST_STOP && scan_end_in && sw_on && !sw_was_on |=>
    state == ST_RUN)
    else $error("switch to on did not run");
  input_start_a: assert property (state == ST_STOP && scan_end_in && sw_on && ctrl.startup_en
    && sel_x && !x_was |=> state == ST_RUN)
    else $error("input rising edge did not run");
  boot_stop_a: assert property (state == ST_BOOT && scan_end_in && !sw_on |=> state == ST_STOP)
    else $error("reset with switch off did not stop");
  switch_off_a: assert property (state == ST_RUN && scan_end_in && sw_s2 == SW_OFF |=>
    state == ST_STOP && !run_out)
    else $error("switch off did not stop");
  stop_cmd_a: assert property (state == ST_RUN && scan_end_in && stop_pend |=> state == ST_STOP)
    else $error("stop command ignored");
  fault_halt_a: assert property (fault_now |=> !tasks_out.user_prog && err_lamp_out)
    else $error("serious fault did not halt");
  stop_off_a: assert property (next_state != ST_RUN && ctrl.policy == OUT_OFF |=> y_out == '0)
    else $error("stopped outputs not off");
  stop_freeze_a: assert property (state == ST_RUN && next_state == ST_STOP
    && ctrl.policy == OUT_FREEZE |=> $stable(y_out))
    else $error("outputs not frozen on stop");
  sys_code_a: assert property (sys_err_req_in[0] |=> sys_flag && sys_code_reg == SYS_CODE_BASE)
    else $error("worst system error not kept");
  exec_ok_a: assert property (exec_ok_in && !exec_err_in |=> !exec_flag && $stable(exec_stack[0]))
    else $error("correct instruction mishandled flag");
  mild_lamp_a: assert property (!err_lamp_out && exec_err_in && !exec_err_serious_in && !sys_serious
    |=> !err_lamp_out)
    else $error("mild error lit lamp");
  clear_stop_a: assert property (|clr_go_out |-> $past(state) == ST_STOP)
    else $error("clear outside stop");
  upload_a: assert property (upload_grant_out |-> $past(upload_en))
    else $error("upload granted while disabled");

  run_to_stop_c: cover property (state == ST_RUN ##1 state == ST_STOP);
  input_start_c: cover property (state == ST_STOP && ctrl.startup_en ##1 state == ST_RUN);
  upload_block_c: cover property (upload_refused_out);

endmodule // rsc_run_stop
`default_nettype wire

// file: verif/rsc_far_side.sv
// Model of the mode switch, input terminals and programming computer
`timescale 1ns/1ps
`default_nettype none
module rsc_far_side (
  // Commands from the bench
  input wire logic [1:0] sw_in,
  input wire logic [15:0] x_in,
  input wire logic dl_in,
  input wire logic upl_en_in,
  input wire logic online_in,
  input wire logic upreq_in,
  input wire logic [3:0] clr_in,
  // Device state
  input wire logic run_in,
  // Device pins
  output logic [1:0] switch_pin_out,
  output logic [15:0] x_pin_out,
  output logic dl_done_out,
  output logic dl_upload_en_out,
  output logic upload_req_out,
  output logic [3:0] clr_req_out
);
  assign switch_pin_out = sw_in;
  assign x_pin_out = x_in;
  // Downloads only while stopped, or while editing online
  assign dl_done_out = dl_in & (~run_in | online_in);
  // Level means nothing outside a download, so it is scrambled there
  assign dl_upload_en_out = dl_done_out ? upl_en_in : ~upl_en_in;
  assign upload_req_out = upreq_in;
  assign clr_req_out = clr_in;
endmodule // rsc_far_side
`default_nettype wire

// file: verif/test_rsc_run_stop.sv
// Self-checking bench of the run/stop and error control block
`timescale 1ns/1ps
`default_nettype none
module test_rsc_run_stop import rsc_pkg::*;;
  logic clk_sys_in, reset_in = 1'b1, scan_end = 1'b0, stop_cmd = 1'b0, exec_err = 1'b0;
  logic exec_ser = 1'b0, exec_ok = 1'b0, dl = 1'b0, upl_en = 1'b0, online = 1'b0, upreq = 1'b0;
  rsc_bus_s bus = '0;
  logic [1:0] sw = SW_OFF;
  logic [15:0] xc = '0, y_img = '0, code = '0;
  logic [3:0] sys_err = '0, clr_cmd = '0;
  logic [31:0] rd_data, lfsr = 32'h810a1504;
  logic [1:0] sw_pin;
  logic [15:0] x_pin, y_out, pat;
  logic [3:0] clr_pin, clr_go;
  logic dl_pin, upl_pin, upreq_pin, run, lamp, clr_ref, grant, refused, swap, upl_ok;
  rsc_tasks_s tasks;
  int err_count = 0, samples_checked = 0, cycles = 0, pol;
  int stk[$];
  logic [15:0] exp_y, a;

  rsc_far_side i_rsc_far_side (.sw_in(sw), .x_in(xc), .dl_in(dl), .upl_en_in(upl_en),
    .online_in(online), .upreq_in(upreq), .clr_in(clr_cmd), .run_in(run), .switch_pin_out(sw_pin),
    .x_pin_out(x_pin), .dl_done_out(dl_pin), .dl_upload_en_out(upl_pin),
    .upload_req_out(upreq_pin), .clr_req_out(clr_pin));

  rsc_run_stop i_rsc_run_stop (.clk_sys_in(clk_sys_in), .reset_in(reset_in), .bus_in(bus),
    .rd_data_out(rd_data), .switch_pin_in(sw_pin), .x_pin_in(x_pin), .scan_end_in(scan_end),
    .y_image_in(y_img), .stop_cmd_in(stop_cmd), .sys_err_req_in(sys_err), .exec_err_in(exec_err),
    .exec_err_code_in(code), .exec_err_serious_in(exec_ser), .exec_ok_in(exec_ok),
    .clr_req_in(clr_pin), .dl_done_in(dl_pin), .dl_upload_en_in(upl_pin),
    .upload_req_in(upreq_pin), .tasks_out(tasks), .run_out(run), .y_out(y_out),
    .err_lamp_out(lamp), .clr_go_out(clr_go), .clr_refused_out(clr_ref),
    .upload_grant_out(grant), .upload_refused_out(refused), .prog_swap_out(swap));

  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end

  // Run takes well under a thousand cycles
  always @(posedge clk_sys_in) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge clk_sys_in) bus <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
    @(posedge clk_sys_in) bus <= '0;
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge clk_sys_in) bus <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 32'h0};
    @(posedge clk_sys_in) bus <= '0;
    #1 d = rd_data;
  endtask

  task automatic wrctrl(input logic [7:0] v);
    wr(OFS_CTRL, 32'(v));
    pol = int'(v[1:0]);
  endtask

  task automatic stat(input int b, input logic e);
    logic [31:0] d;
    rd(OFS_STATUS, d);
    chk(32'(d[b]), 32'(e));
  endtask

  task automatic rst();
    @(posedge clk_sys_in) reset_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    stk = '{0, 0, 0, 0, 0};
    exp_y = '0;
    pol = 0;
    upl_ok = 1'b1;
  endtask

  // Pins are given four cycles to pass their synchronisers before the boundary
  task automatic scan(input logic [1:0] sv, input logic [15:0] ny, input logic er);
    @(posedge clk_sys_in) begin
      sw <= sv;
      y_img <= ny;
    end
    repeat (3) @(posedge clk_sys_in);
    @(posedge clk_sys_in) scan_end <= 1'b1;
    @(posedge clk_sys_in) scan_end <= 1'b0;
    #1 exp_y = er ? ny : (pol == 2 ? pat : (pol == 1 ? exp_y : 16'h0));
    chk(32'(run), 32'(er));
    chk(32'(tasks), {28'h0, er, 3'b111});
    chk(32'(y_out), 32'(exp_y));
  endtask

  task automatic clr(input logic ok);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_in) clr_cmd <= 4'(1 << i);
      @(posedge clk_sys_in) clr_cmd <= '0;
      #1 chk(32'(clr_go), ok ? 32'(1 << i) : 32'h0);
      chk(32'(clr_ref), 32'(!ok));
    end
  endtask

  task automatic exe(input logic [15:0] c, input logic s);
    @(posedge clk_sys_in) begin
      exec_err <= 1'b1;
      code <= c;
      exec_ser <= s;
    end
    @(posedge clk_sys_in) exec_err <= 1'b0;
    if (stk[0] != int'(c)) begin
      stk.push_front(int'(c));
      void'(stk.pop_back());
    end
    #1 chk(32'(lamp), 32'(s));
    stat(ST_BIT_EXEC_FLAG, 1'b1);
  endtask

  task automatic dload(input logic en, input logic onl);
    @(posedge clk_sys_in) begin
      dl <= 1'b1;
      upl_en <= en;
      online <= onl;
    end
    @(posedge clk_sys_in) dl <= 1'b0;
    #1 chk(32'(swap), 32'h1);
    upl_ok = en;
  endtask

  task automatic upload();
    @(posedge clk_sys_in) upreq <= 1'b1;
    @(posedge clk_sys_in) upreq <= 1'b0;
    #1 chk(32'(grant), 32'(upl_ok));
    chk(32'(refused), 32'(!upl_ok));
  endtask

  task automatic syserr(input logic [3:0] v);
    logic [31:0] d;
    int w;
    w = 0;
    while (!v[w]) w++;
    @(posedge clk_sys_in) sys_err <= v;
    @(posedge clk_sys_in) sys_err <= '0;
    #1 chk(32'(lamp), 32'(w < 2));
    chk(32'(tasks.user_prog), 32'(w >= 2));
    rd(OFS_SYS_CODE, d);
    chk(d, 32'(w + 1));
    stat(ST_BIT_SYS_FLAG, 1'b1);
  endtask

  initial begin
    logic [31:0] d;
    rst();
    scan(SW_OFF, rnd(), 1'b0);
    clr(1'b1);
    scan(SW_ON, rnd(), 1'b1);
    clr(1'b0);
    for (int p = 0; p < 3; p++) begin
      pat = rnd();
      wr(OFS_PATTERN, 32'(pat));
      wrctrl(8'(p));
      scan(SW_OFF, y_img, 1'b0);
      @(posedge clk_sys_in) y_img <= rnd();
      repeat (3) @(posedge clk_sys_in);
      #1 chk(32'(y_out), 32'(exp_y));
      scan(SW_ON, rnd(), 1'b1);
    end
    @(posedge clk_sys_in) stop_cmd <= 1'b1;
    @(posedge clk_sys_in) stop_cmd <= 1'b0;
    scan(SW_ON, y_img, 1'b0);
    wrctrl(8'h5a);
    scan(SW_ON, y_img, 1'b0);
    @(posedge clk_sys_in) xc <= 16'h0020;
    scan(SW_ON, rnd(), 1'b1);
    a = rnd() | 16'h0001;
    for (int i = 0; i < 12; i++) begin
      exe(a + 16'(i / 2), 1'b0);
    end
    @(posedge clk_sys_in) exec_ok <= 1'b1;
    @(posedge clk_sys_in) exec_ok <= 1'b0;
    stat(ST_BIT_EXEC_FLAG, 1'b0);
    for (int i = 0; i < 5; i++) begin
      rd(OFS_STACK0 + 8'(4 * i), d);
      chk(d, 32'(stk[i]));
    end
    exe(~a, 1'b1);
    chk(32'(tasks.user_prog), 32'h0);
    scan(SW_ON, y_img, 1'b0);
    dload(1'b0, 1'b0);
    upload();
    dload(1'b1, 1'b0);
    upload();
    rst();
    wrctrl(8'h34);
    scan(SW_ON, rnd(), 1'b0);
    rst();
    wrctrl(8'h34);
    @(posedge clk_sys_in) xc <= 16'h0008;
    scan(SW_ON, rnd(), 1'b1);
    scan(SW_PROG_ONLY, rnd(), 1'b1);
    dload(1'b1, 1'b1);
    syserr(4'b1100);
    syserr(4'b0110);
    rst();
    scan(SW_PROG_ONLY, rnd(), 1'b0);
    conclude();
  end
endmodule // test_rsc_run_stop
`default_nettype wire
